// File: hw/card_regs_pkg.sv
// Constants, offsets and encodings of the card register set
package card_regs_pkg;

  // Register widths in bits
  localparam int COND_BITS      = 32;
  localparam int IDENT_BITS     = 128;
  localparam int CDATA_BITS     = 128;
  localparam int CARD_ADDR_BITS = 16;
  localparam int DRIVER_BITS    = 16;
  localparam int CONFIG_BITS    = 64;
  localparam int STATUS_BITS    = 512;

  // Word counts of the wide registers
  localparam int IDENT_WORDS  = IDENT_BITS / 32;
  localparam int CDATA_WORDS  = CDATA_BITS / 32;
  localparam int CONFIG_WORDS = CONFIG_BITS / 32;
  localparam int STATUS_WORDS = STATUS_BITS / 32;
  localparam int MEM_WORDS    = IDENT_WORDS + CDATA_WORDS + CONFIG_WORDS + STATUS_WORDS;

  // Word bases inside the shared store
  localparam logic [4:0] IDENT_BASE  = 5'h00;
  localparam logic [4:0] CDATA_BASE  = 5'h04;
  localparam logic [4:0] CONFIG_BASE = 5'h08;
  localparam logic [4:0] STATUS_BASE = 5'h0A;
  localparam logic [4:0] MEM_LAST    = 5'h19;

  // Operating-conditions field masks
  localparam logic [31:0] COND_BUSY_MASK = 32'h8000_0000;
  localparam logic [31:0] COND_CCS_MASK  = 32'h4000_0000;
  localparam logic [31:0] COND_LV_MASK   = 32'h0100_0000;
  localparam logic [31:0] COND_VWIN_MASK = 32'h00FF_8000;
  localparam logic [31:0] COND_USED_MASK = 32'hC1FF_8000;
  localparam logic [31:0] COND_RESET     = 32'h00FF_8000;

  // Capability flag for the driver stage inside the card-specific data
  localparam logic [1:0]  DRV_FLAG_WORD  = 2'h1;
  localparam logic [31:0] DRV_FLAG_MASK  = 32'h0000_1000;

  // AHB register byte offsets
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] COND_OFF      = 8'h04;
  localparam logic [7:0] CARD_ADDR_OFF = 8'h08;
  localparam logic [7:0] MEM_SEL_OFF   = 8'h0C;
  localparam logic [7:0] MEM_DATA_OFF  = 8'h10;

  // Control register bits
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_LV_BIT   = 1;
  localparam int CTRL_CCS_BIT  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Response path register selects
  typedef enum logic [2:0] {
    SEL_COND   = 3'h0,
    SEL_IDENT  = 3'h1,
    SEL_CDATA  = 3'h2,
    SEL_ADDR   = 3'h3,
    SEL_DRIVER = 3'h4,
    SEL_CONFIG = 3'h5,
    SEL_STATUS = 3'h6
  } reg_sel_t;

  // Power-up sequence, one-hot
  typedef enum logic [2:0] {
    ST_POWER = 3'b001,
    ST_INIT  = 3'b010,
    ST_READY = 3'b100
  } pwr_state_t;

  // Power-up settle in SD clocks before init can complete
  localparam int PWRUP_CLOCKS = 74;

endpackage : card_regs_pkg

// File: hw/card_register_set.sv
// Card-side register set with firmware AHB port and response read port
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - A 32-bit operating-conditions register reports voltage support and power-up status.
// - Bit 31 reads 0 while busy, 1 only after power-up and init complete.
// - Bits 23..15 read 1 for 3.6V to 2.7V; bits 14..4 read 0.
// - Bit 24 flags an accepted 1.8V signalling switch; it resets to 0.
// - Reserved bits 29..25, 14..8, 7 and 6..0 always read 0.
// - Identity 128, card data 128, address 16, configuration 64, status 512 bits.
// - No driver-stage register; card data reports it absent.
module card_register_set
  import card_regs_pkg::*;
#(
  parameter int PWRUP_CYCLES = card_regs_pkg::PWRUP_CLOCKS
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // AHB-Lite firmware port
  input  wire logic                    hsel,
  input  wire logic [7:0]              haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output      logic [31:0]             hrdata,
  output      logic                    hreadyout,
  output      logic                    hresp,
  // Response path read port
  input  wire logic                    rspReq,
  input  wire card_regs_pkg::reg_sel_t rspSel,
  input  wire logic [3:0]              rspWord,
  output      logic                    rspValid,
  output      logic [31:0]             rspData,
  // Status
  output      logic                    cardReady
);

  // Settle counter is sixteen bits wide
  if (PWRUP_CYCLES < 1 || PWRUP_CYCLES > 65535) begin : g_bad_pwrup
    $error("PWRUP_CYCLES out of range");
  end
  // Store map must match the five-bit pointer range
  if (MEM_WORDS != int'(MEM_LAST) + 1) begin : g_bad_map
    $error("store map inconsistent");
  end

  // Registers
  logic [31:0] memStore [0:MEM_WORDS-1];
  logic [2:0]  ctrl_r;
  logic [15:0] cardAddr_r;
  logic [4:0]  memSel_r;
  pwr_state_t  state_r;
  pwr_state_t  state_nxt;
  logic [15:0] pwrCnt_r;
  logic        wrPend_r;
  logic        rdPend_r;
  logic [7:0]  dAddr_r;
  logic [31:0] hrdata_r;
  logic        rspValid_r;
  logic [31:0] rspData_r;
  logic [31:0] condValue;
  logic        addrTaken;
  logic        condBusy;
  logic        condCcs;
  logic        condLv;
  logic [31:0] hrdata_nxt;
  logic [31:0] rspData_nxt;
  logic [4:0]  rspIndex;
  logic        rspInRange;

  // Operating-conditions fields, one flag at a time
  always_comb begin
    condBusy = (state_r == ST_READY);
    condCcs  = ctrl_r[CTRL_CCS_BIT];
    condLv   = ctrl_r[CTRL_LV_BIT];
  end

  // Operating-conditions value built from masks
  always_comb begin
    condValue = COND_VWIN_MASK;
    if (condBusy) begin
      condValue = condValue | COND_BUSY_MASK;
    end
    if (condCcs) begin
      condValue = condValue | COND_CCS_MASK;
    end
    if (condLv) begin
      condValue = condValue | COND_LV_MASK;
    end
    // Final mask so no stray field can ever leak into reserved bits
    condValue = condValue & COND_USED_MASK;
  end

  // Power-up sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POWER: begin
        if (pwrCnt_r == 16'(PWRUP_CYCLES - 1)) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (ctrl_r[CTRL_INIT_BIT]) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (!ctrl_r[CTRL_INIT_BIT]) begin
          state_nxt = ST_INIT;
        end
      end
      default: state_nxt = ST_POWER;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_POWER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle counter runs only while powering up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwrCnt_r <= 16'h0000;
    end else if (state_r == ST_POWER) begin
      pwrCnt_r <= pwrCnt_r + 16'h0001;
    end
  end

  // AHB address phase
  assign addrTaken = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      dAddr_r  <= 8'h00;
    end else begin
      wrPend_r <= addrTaken && hwrite;
      rdPend_r <= addrTaken && !hwrite;
      if (addrTaken) begin
        dAddr_r <= haddr;
      end
    end
  end

  // Control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wrPend_r && dAddr_r == CTRL_OFF) begin
      ctrl_r <= hwdata[2:0];
    end
  end

  // Relative address, loaded by firmware
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cardAddr_r <= 16'h0000;
    end else if (wrPend_r && dAddr_r == CARD_ADDR_OFF) begin
      cardAddr_r <= hwdata[CARD_ADDR_BITS-1:0];
    end
  end

  // Store pointer, advances after each data write for streaming loads and holds at MEM_LAST
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memSel_r <= 5'h00;
    end else if (wrPend_r && dAddr_r == MEM_SEL_OFF) begin
      memSel_r <= hwdata[4:0];
    end else if (wrPend_r && dAddr_r == MEM_DATA_OFF && memSel_r != MEM_LAST) begin
      memSel_r <= memSel_r + 5'h01;
    end
  end

  // Wide register store, no reset: firmware loads it before init completes
  always_ff @(posedge ref_clk) begin
    if (wrPend_r && dAddr_r == MEM_DATA_OFF && memSel_r <= MEM_LAST) begin
      memStore[memSel_r] <= hwdata;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    unique case (dAddr_r)
      CTRL_OFF: begin
        hrdata_nxt = {29'h0000_0000, ctrl_r};
      end
      COND_OFF: begin
        hrdata_nxt = condValue;
      end
      CARD_ADDR_OFF: begin
        hrdata_nxt = {16'h0000, cardAddr_r};
      end
      MEM_SEL_OFF: begin
        hrdata_nxt = {27'h000_0000, memSel_r};
      end
      MEM_DATA_OFF: begin
        if (memSel_r <= MEM_LAST) begin
          hrdata_nxt = memStore[memSel_r];
        end
      end
      default: begin
        hrdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data sampled one cycle late so a preceding write is visible
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rdPend_r) begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // One wait state on reads, none on writes
  logic rdWait_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdWait_r <= 1'b0;
    end else begin
      rdWait_r <= rdPend_r;
    end
  end

  assign hreadyout = !(rdPend_r && !rdWait_r);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Response word select; a word past the register's end reads zero
  always_comb begin
    rspData_nxt = 32'h0000_0000;
    rspIndex    = 5'h00;
    rspInRange  = 1'b0;
    unique case (rspSel)
      SEL_COND: begin
        rspInRange = (rspWord == 4'h0);
        if (rspInRange) begin
          rspData_nxt = condValue;
        end
      end
      SEL_IDENT: begin
        rspInRange = (rspWord < 4'(IDENT_WORDS));
        rspIndex   = IDENT_BASE + 5'(rspWord);
        if (rspInRange) begin
          rspData_nxt = memStore[rspIndex];
        end
      end
      SEL_CDATA: begin
        rspInRange = (rspWord < 4'(CDATA_WORDS));
        rspIndex   = CDATA_BASE + 5'(rspWord);
        if (rspInRange) begin
          rspData_nxt = memStore[rspIndex];
          // Firmware may load any image; the capability flag is forced clear
          if (rspWord[1:0] == DRV_FLAG_WORD) begin
            rspData_nxt = memStore[rspIndex] & ~DRV_FLAG_MASK;
          end
        end
      end
      SEL_ADDR: begin
        rspInRange = (rspWord == 4'h0);
        if (rspInRange) begin
          rspData_nxt = {16'h0000, cardAddr_r};
        end
      end
      SEL_DRIVER: begin
        rspData_nxt = 32'h0000_0000;
      end
      SEL_CONFIG: begin
        rspInRange = (rspWord < 4'(CONFIG_WORDS));
        rspIndex   = CONFIG_BASE + 5'(rspWord);
        if (rspInRange) begin
          rspData_nxt = memStore[rspIndex];
        end
      end
      SEL_STATUS: begin
        // Sixteen words cover every index the port can carry
        rspInRange  = 1'b1;
        rspIndex    = STATUS_BASE + 5'(rspWord);
        rspData_nxt = memStore[rspIndex];
      end
      default: begin
        rspData_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Response path: the only way contents leave toward the host
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rspValid_r <= 1'b0;
      rspData_r  <= 32'h0000_0000;
    end else begin
      rspValid_r <= rspReq;
      if (rspReq) begin
        rspData_r <= rspData_nxt;
      end
    end
  end

  assign rspValid  = rspValid_r;
  assign rspData   = rspData_r;
  // Host polls the ready bit; this mirrors it for the command logic
  assign cardReady = (state_r == ST_READY);

endmodule : card_register_set

// File: tb/card_regs_checker.sv
// Port assertions for the card register set
`timescale 1ns/1ps
module card_regs_checker
  import card_regs_pkg::*;
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst,
  // AHB-Lite
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  // Response port
  input wire logic                    rspReq,
  input wire card_regs_pkg::reg_sel_t rspSel,
  input wire logic [3:0]              rspWord,
  input wire logic                    rspValid,
  input wire logic [31:0]             rspData,
  input wire logic                    cardReady
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  // One wait state, then completion
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence cond_rd;
    rspValid && $past(rspSel) == SEL_COND && $past(rspWord) == 4'h0;
  endsequence
  a_rsp_valid: assert property (rspReq |=> rspValid)
    else $error("no response after request");
  a_rsp_quiet: assert property (!rspReq |=> !rspValid)
    else $error("response without request");
  a_read_wait: assert property (tk && !hwrite |=> rd_wait)
    else $error("read wait state wrong");
  a_hresp_okay: assert property (!hresp)
    else $error("error response seen");
  a_cond_window: assert property (cond_rd |-> rspData[23:4] == 20'hFF800)
    else $error("voltage window wrong");
  a_cond_reserved: assert property (cond_rd |-> rspData[29:25] == 5'h00 && rspData[3:0] == 4'h0)
    else $error("reserved bits set");
  a_cond_busy: assert property (cond_rd |-> rspData[31] == $past(cardReady))
    else $error("busy bit disagrees with ready");
  a_driver_absent: assert property (rspValid && $past(rspSel) == SEL_DRIVER |-> rspData == 32'h0)
    else $error("driver stage not zero");
  a_driver_flag: assert property (rspValid && $past(rspSel) == SEL_CDATA && $past(rspWord) == 4'h1 |-> !rspData[12])
    else $error("driver stage flag set");
endmodule : card_regs_checker

bind card_register_set card_regs_checker chk (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hsize,
  .hready, .hreadyout, .hresp, .rspReq, .rspSel, .rspWord, .rspValid, .rspData, .cardReady);

// File: tb/sd_host_model.sv
// Host controller model reading registers over the response port
`timescale 1ns/1ps
module sd_host_model
  import card_regs_pkg::*;
(
  // Clock
  input  wire logic                    ref_clk,
  // Response port
  output      card_regs_pkg::reg_sel_t rspSel,
  output      logic                    rspReq,
  output      logic [3:0]              rspWord,
  input  wire logic                    rspValid,
  input  wire logic [31:0]             rspData
);
  initial begin
    rspReq = 1'b0;
    rspSel = SEL_COND;
    rspWord = 4'h0;
  end
  task automatic fetch(input reg_sel_t s, input logic [3:0] w, output logic [31:0] d);
    @(posedge ref_clk);
    rspReq <= 1'b1;
    rspSel <= s;
    rspWord <= w;
    @(posedge ref_clk);
    rspReq <= 1'b0;
    // Idle selects wander so stale values are not trusted
    rspSel <= SEL_DRIVER;
    rspWord <= ~w;
    #1;
    d = rspValid ? rspData : 32'hXXXXXXXX;
  endtask : fetch
  task automatic poll(output logic rdy);
    logic [31:0] d;
    rdy = 1'b0;
    for (int i = 0; i < 50 && !rdy; i++) begin
      fetch(SEL_COND, 4'h0, d);
      rdy = d[31] === 1'b1;
    end
  endtask : poll
endmodule : sd_host_model

// File: tb/tb.sv
// Self-checking bench for the card register set
`timescale 1ns/1ps
module tb;
  import card_regs_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, hsel, hwrite, hreadyout, hresp, rspReq, rspValid, cardReady;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] rspWord;
  logic [31:0] hwdata, hrdata, rspData, d;
  reg_sel_t rspSel;
  logic r;
  int n_mismatch = 0, tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  card_register_set #(.PWRUP_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rspReq(rspReq), .rspSel(rspSel), .rspWord(rspWord), .rspValid(rspValid),
    .rspData(rspData), .cardReady(cardReady));
  sd_host_model host (.ref_clk(ref_clk), .rspSel(rspSel), .rspReq(rspReq),
    .rspWord(rspWord), .rspValid(rspValid), .rspData(rspData));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    logic rdy;
    n = 0;
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    // Ready is read settled before the edge it qualifies, never racing it
    do begin
      @(negedge ref_clk);
      rdy = hreadyout;
      @(posedge ref_clk);
    end while (!rdy && ++n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge ref_clk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge ref_clk);
    end while (!rdy && ++n < 20);
    if (!rdy) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : bus
  function automatic logic [31:0] expw(input int s, input int w);
    int b, n;
    logic [31:0] v;
    b = (s == 1) ? 0 : (s == 2) ? 4 : (s == 5) ? 8 : 10;
    n = (s == 1 || s == 2) ? 4 : (s == 5) ? 2 : (s == 6) ? 16 : 0;
    v = (w < n) ? 32'hC0DE1000 + b + w : 32'h0;
    if (s == 3 && w == 0) v = 32'h0000ABCD;
    if (s == 2 && w == 1) v[12] = 1'b0;
    return v;
  endfunction : expw
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, COND_OFF, 32'h0, d);
    chk("cond after reset", 32'h00FF8000, d);
    bus(1'b0, 8'h14, 32'h0, d);
    chk("unmapped", 32'h0, d);
    host.fetch(SEL_COND, 4'h0, d);
    chk("cond busy", 32'h00FF8000, d);
    bus(1'b1, CTRL_OFF, 32'h7, d);
    bus(1'b0, CTRL_OFF, 32'h0, d);
    chk("ctrl readback", 32'h7, d);
    host.poll(r);
    chk("ready", 32'h1, {31'h0, r});
    chk("ready pin", 32'h1, {31'h0, cardReady});
    host.fetch(SEL_COND, 4'h0, d);
    chk("cond ready", 32'hC1FF8000, d);
    host.fetch(SEL_COND, 4'h1, d);
    chk("cond past end", 32'h0, d);
    bus(1'b1, CARD_ADDR_OFF, 32'hFFFFABCD, d);
    bus(1'b0, CARD_ADDR_OFF, 32'h0, d);
    chk("address readback", 32'h0000ABCD, d);
    bus(1'b1, MEM_SEL_OFF, 32'h0, d);
    for (int i = 0; i < 26; i++) bus(1'b1, MEM_DATA_OFF, 32'hC0DE1000 + i, d);
    bus(1'b0, MEM_SEL_OFF, 32'h0, d);
    chk("pointer stop", 32'h19, d);
    bus(1'b1, MEM_SEL_OFF, 32'h5, d);
    bus(1'b0, MEM_DATA_OFF, 32'h0, d);
    chk("store raw", 32'hC0DE1005, d);
    for (int s = 1; s < 7; s++) for (int w = 0; w < 16; w++) begin
      host.fetch(reg_sel_t'(s), w[3:0], d);
      chk("register word", expw(s, w), d);
    end
    bus(1'b1, CTRL_OFF, 32'h2, d);
    repeat (2) @(posedge ref_clk);
    host.fetch(SEL_COND, 4'h0, d);
    chk("cond busy again", 32'h01FF8000, d);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    host.fetch(SEL_COND, 4'h0, d);
    chk("cond second reset", 32'h00FF8000, d);
    give_verdict();
  end
endmodule : tb
